// file: serial_pins_pkg.sv
// Package with modes, carriers and timing constants for the serial pin mux
package serial_pins_pkg;

	// Interface mode as configured by software
	typedef enum logic [1:0]
	{
		MODE_LEGACY = 2'h0,
		MODE_EXTENDED = 2'h1,
		MODE_HDLC = 2'h2
	} if_mode_t;

	// Width of the slot number within a frame
	localparam int SLOT_W = 5;
	// Width of the bit counter inside one slot
	localparam int BIT_W = 3;
	// Reset pulse length on the reset output, in system clocks
	localparam int RESET_PULSE_CYCLES = 16;
	// Width of the reset pulse counter
	localparam int RESET_CNT_W = 5;
	// Least reset input hold, in system clocks
	localparam int RESET_MIN_CYCLES = 4;
	// Reset values of the pin functions
	localparam logic STROBE_ONE_AFTER_RESET = 1'h1;
	localparam logic STROBE_TWO_AFTER_RESET = 1'h1;

	// Configuration written by software
	typedef struct packed
	{
		if_mode_t mode;
		logic [SLOT_W-1:0] strobe_one_slot_a;
		logic [SLOT_W-1:0] strobe_one_slot_b;
		logic strobe_one_dual;
		logic [SLOT_W-1:0] strobe_two_slot;
		logic terminal_funcs_en;
		logic reset_out_en;
	} port_cfg_t;

	// Pin bundle of a two-way pin
	typedef struct packed
	{
		logic o;
		logic oe;
	} pin_drive_t;

endpackage

// file: link_slot_timer.sv
// Link-clock side: frame timing, strobes and serial shifting
`timescale 1ns/1ps
module link_slot_timer
	import serial_pins_pkg::*;
(
	// Link clock and synchronised reset
	input wire logic bit_clock_in,
	input wire logic link_rst,
	// Frame sync from the partner
	input wire logic frame_sync,
	// Configuration, static while frames run
	input wire port_cfg_t cfg,
	input wire logic cfg_written,
	// Serial data
	input wire logic tx_bit,
	input wire logic port_a_rx_data,
	input wire logic slot_link_in,
	// Pin outputs
	output logic shared_one_o,
	output logic shared_two_o,
	output logic slot_link_o,
	output logic slot_link_oe,
	output logic rx_sample
);

	// ==========================================================
	// State
	typedef struct packed
	{
		logic [SLOT_W-1:0] slot;
		logic [BIT_W-1:0] bit_cnt;
		logic half;
		logic one;
		logic two;
		logic sl_o;
		logic sl_oe;
		logic rx;
	} link_state_t;

	link_state_t st_r;
	link_state_t st_nxt;
	logic in_one;

	// ==========================================================
	// Next state
	always_comb
	begin
		st_nxt = st_r;
		// Frame sync restarts slot and bit counting
		if (frame_sync)
		begin
			st_nxt.slot = '0;
			st_nxt.bit_cnt = '0;
			st_nxt.half = 1'b0;
		end
		else if (cfg.mode == MODE_HDLC)
		begin
			// One clock per data bit
			st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
			if (st_r.bit_cnt == '1)
				st_nxt.slot = st_r.slot + 1'b1;
		end
		else
		begin
			// Two clocks per data bit in frame modes
			st_nxt.half = ~st_r.half;
			if (st_r.half)
			begin
				st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
				if (st_r.bit_cnt == '1)
					st_nxt.slot = st_r.slot + 1'b1;
			end
		end
		in_one = (st_r.slot == cfg.strobe_one_slot_a) ||
			(cfg.strobe_one_dual && st_r.slot == cfg.strobe_one_slot_b);
		// Pin functions by mode
		if (!cfg_written)
		begin
			// Strobes until configured
			st_nxt.one = in_one;
			st_nxt.two = st_r.slot == cfg.strobe_two_slot;
			st_nxt.sl_oe = 1'b0;
			st_nxt.sl_o = 1'b0;
		end
		else
		begin
			unique case (cfg.mode)
				MODE_LEGACY:
				begin
					// Transmit bits on shared pin
					st_nxt.one = tx_bit;
					// Frame-sync delayed function on pin two
					st_nxt.two = st_r.slot == '0;
					// Slot link drives in even slots, listens in odd slots
					st_nxt.sl_oe = ~st_r.slot[0];
					st_nxt.sl_o = tx_bit;
				end
				MODE_EXTENDED:
				begin
					// Programmable channel strobes
					st_nxt.one = in_one;
					st_nxt.two = st_r.slot == cfg.strobe_two_slot;
					st_nxt.sl_oe = 1'b0;
					st_nxt.sl_o = 1'b0;
				end
				default:
				begin
					// HDLC: pin two carries the bit clock phase
					st_nxt.one = 1'b0;
					st_nxt.two = st_r.bit_cnt[0];
					st_nxt.sl_oe = 1'b0;
					st_nxt.sl_o = 1'b0;
				end
			endcase
		end
		// Port A receive only in legacy mode
		if (cfg_written && cfg.mode == MODE_LEGACY)
			st_nxt.rx = st_r.sl_oe ? port_a_rx_data : slot_link_in;
		else
			st_nxt.rx = 1'b0;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge bit_clock_in or posedge link_rst)
	begin
		if (link_rst)
		begin
			st_r <= '0;
			st_r.one <= 1'b0;
		end
		else
			st_r <= st_nxt;
	end

	assign shared_one_o = st_r.one;
	assign shared_two_o = st_r.two;
	assign slot_link_o = st_r.sl_o;
	assign slot_link_oe = st_r.sl_oe;
	assign rx_sample = st_r.rx;

endmodule

// file: serial_port_pin_functions.sv
// Serial port pin function mux with external awake and reset pulse
`timescale 1ns/1ps
// Notes on behaviour
// - Non-multiplexed bus uses six address inputs
// - Port A receive sampled only in legacy
// - Slot link pin both transmits and receives in legacy
// - Awake falling edge raises interrupt, optional reset
// - Legacy mode shifts transmit on shared pin
// - Extended mode strobe one marks chosen slots
// - Shared pin one is strobe after reset
// - Shared pin two is strobe after reset
module serial_port_pin_functions
	import serial_pins_pkg::*;
(
	// System clock and reset
	input wire logic clock,
	input wire logic rst,
	// Configuration from the register block
	input wire port_cfg_t cfg_in,
	input wire logic cfg_write,
	input wire logic nonmux_bus_sel,
	// Address pins
	input wire logic [5:0] addr_lines,
	// Link side
	input wire logic bit_clock_in,
	input wire logic frame_sync,
	input wire logic tx_bit,
	input wire logic port_a_rx_data,
	input wire logic slot_link_in,
	// Pins out
	output logic slot_link_o,
	output logic slot_link_oe,
	output logic port_a_tx_data,
	output logic channel_strobe_two,
	// Towards the core
	output logic [5:0] reg_addr,
	output logic rx_data_sync,
	output logic awake_irq,
	output logic reset_io_o,
	output logic reset_io_oe
);

	// ==========================================================
	// State of the system clock domain
	typedef struct packed
	{
		port_cfg_t cfg;
		logic written;
		logic [1:0] awake_sync;
		logic awake_prev;
		logic irq;
		logic [RESET_CNT_W-1:0] rst_cnt;
		logic rst_o;
		logic [1:0] rx_sync;
		logic rx;
		logic [5:0] addr_meta;
		logic [5:0] addr_stab;
		logic [5:0] addr;
	} sys_state_t;

	sys_state_t s_r;
	sys_state_t s_nxt;

	// Link-domain configuration copy, updated on a write handshake
	port_cfg_t link_cfg_r;
	logic link_written_r;
	logic [1:0] link_rst_sync_r;
	logic [1:0] wr_tgl_sync_r;
	logic wr_tgl_seen_r;
	logic wr_tgl_r;

	// Link-domain pin outputs
	logic one_o;
	logic two_o;
	logic sl_o;
	logic sl_oe;
	logic rx_link;
	logic [1:0] one_sync_r;
	logic [1:0] two_sync_r;
	logic [1:0] sl_sync_r;
	logic [1:0] sloe_sync_r;
	logic awake_pin;

	// ==========================================================
	// The slot link line doubles as the external awake input
	assign awake_pin = slot_link_in;

	// ==========================================================
	// System domain next state
	always_comb
	begin
		s_nxt = s_r;
		// Config write is flagged once; hold config stable after
		if (cfg_write)
		begin
			s_nxt.cfg = cfg_in;
			s_nxt.written = 1'b1;
		end
		// Address pins are asynchronous: two flops before any use
		s_nxt.addr_meta = addr_lines;
		s_nxt.addr_stab = s_r.addr_meta;
		// Address taken from dedicated lines in non-mux bus
		s_nxt.addr = nonmux_bus_sel ? s_r.addr_stab : 6'h00;
		// Awake synchroniser, edge on second stage only
		s_nxt.awake_sync = {s_r.awake_sync[0], awake_pin};
		s_nxt.awake_prev = s_r.awake_sync[1];
		s_nxt.irq = 1'b0;
		if (s_r.rst_cnt != '0)
			s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
		if (s_r.cfg.terminal_funcs_en && s_r.awake_prev &&
			!s_r.awake_sync[1])
		begin
			// Falling edge: interrupt and optional reset pulse
			s_nxt.irq = 1'b1;
			if (s_r.cfg.reset_out_en)
				s_nxt.rst_cnt = RESET_CNT_W'(RESET_PULSE_CYCLES);
		end
		s_nxt.rst_o = s_nxt.rst_cnt != '0;
		// Receive data sampled on link side crosses here
		s_nxt.rx_sync = {s_r.rx_sync[0], rx_link};
		s_nxt.rx = s_r.rx_sync[1];
	end

	// ==========================================================
	// System domain registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.awake_sync <= 2'h3;
			s_r.awake_prev <= 1'b1;
			wr_tgl_r <= 1'b0;
		end
		else
		begin
			s_r <= s_nxt;
			if (cfg_write)
				wr_tgl_r <= ~wr_tgl_r;
		end
	end

	// ==========================================================
	// Link domain reset and configuration capture
	// The toggle lags the data by two link edges, so cfg is settled.
	always_ff @(posedge bit_clock_in or posedge rst)
	begin
		if (rst)
		begin
			link_rst_sync_r <= 2'h3;
			wr_tgl_sync_r <= 2'h0;
			wr_tgl_seen_r <= 1'b0;
			link_cfg_r <= '0;
			link_written_r <= 1'b0;
		end
		else
		begin
			link_rst_sync_r <= {link_rst_sync_r[0], 1'b0};
			wr_tgl_sync_r <= {wr_tgl_sync_r[0], wr_tgl_r};
			wr_tgl_seen_r <= wr_tgl_sync_r[1];
			if (wr_tgl_sync_r[1] != wr_tgl_seen_r)
			begin
				link_cfg_r <= s_r.cfg;
				link_written_r <= 1'b1;
			end
		end
	end

	link_slot_timer u_timer
	(
		.bit_clock_in(bit_clock_in),
		.link_rst(link_rst_sync_r[1]),
		.frame_sync(frame_sync),
		.cfg(link_cfg_r),
		.cfg_written(link_written_r),
		.tx_bit(tx_bit),
		.port_a_rx_data(port_a_rx_data),
		.slot_link_in(slot_link_in),
		.shared_one_o(one_o),
		.shared_two_o(two_o),
		.slot_link_o(sl_o),
		.slot_link_oe(sl_oe),
		.rx_sample(rx_link)
	);

	// ==========================================================
	// Pin outputs re-timed to the system clock so every output
	// leaves a flip-flop; costs two cycles of pin latency.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			one_sync_r <= {2{STROBE_ONE_AFTER_RESET}};
			two_sync_r <= {2{STROBE_TWO_AFTER_RESET}};
			sl_sync_r <= 2'h0;
			sloe_sync_r <= 2'h0;
		end
		else
		begin
			one_sync_r <= {one_sync_r[0], one_o};
			two_sync_r <= {two_sync_r[0], two_o};
			sl_sync_r <= {sl_sync_r[0], sl_o};
			sloe_sync_r <= {sloe_sync_r[0], sl_oe};
		end
	end

	assign port_a_tx_data = one_sync_r[1];
	assign channel_strobe_two = two_sync_r[1];
	assign slot_link_o = sl_sync_r[1];
	assign slot_link_oe = sloe_sync_r[1];
	assign reg_addr = s_r.addr;
	assign rx_data_sync = s_r.rx;
	assign awake_irq = s_r.irq;
	assign reset_io_o = s_r.rst_o;
	assign reset_io_oe = s_r.rst_o;

endmodule

// file: serial_port_pin_functions_checker.sv
// Checker for the serial pin function mux
`timescale 1ns/1ps
module serial_port_pin_functions_checker
	import serial_pins_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Inputs watched
	input wire port_cfg_t cfg_in,
	input wire logic cfg_write,
	input wire logic nonmux_bus_sel,
	input wire logic [5:0] addr_lines,
	input wire logic slot_link_in,
	// Outputs watched
	input wire logic slot_link_oe,
	input wire logic port_a_tx_data,
	input wire logic channel_strobe_two,
	input wire logic [5:0] reg_addr,
	input wire logic rx_data_sync,
	input wire logic awake_irq,
	input wire logic reset_io_o
);
// ==========
// Helpers: last config, its age, cycles since reset
port_cfg_t cfg_r;
logic [4:0] age_r;
logic [1:0] up_r;
// Age saturates so link-side latency is long settled
always_ff @(posedge clock or posedge rst)
	if (rst)
	begin
		cfg_r <= '0;
		age_r <= '0;
		up_r <= '0;
	end
	else
	begin
		if (cfg_write)
			cfg_r <= cfg_in;
		if (cfg_write)
			age_r <= 5'h01;
		else if (age_r != 5'h00 && age_r != 5'h1F)
			age_r <= age_r + 5'h01;
		if (up_r != 2'h3)
			up_r <= up_r + 2'h1;
	end
default clocking @(posedge clock); endclocking
default disable iff (rst);
// ==========
// Assertions
a_addr_follow: assert property (nonmux_bus_sel |=>
	reg_addr == $past(addr_lines, 3)) else $error("reg addr wrong");
a_irq_gated: assert property (awake_irq |->
	cfg_r.terminal_funcs_en) else $error("irq while disabled");
a_irq_cause: assert property (awake_irq |->
	!$past(slot_link_in, 3) || !$past(slot_link_in, 4))
	else $error("irq without edge");
a_pulse_len: assert property ($rose(reset_io_o) |->
	reset_io_o[*8] ##1 reset_io_o[*8] ##1 !reset_io_o)
	else $error("reset pulse length");
a_pulse_cause: assert property ($rose(reset_io_o) |->
	awake_irq && cfg_r.reset_out_en) else $error("stray reset pulse");
a_irq_pulse: assert property (awake_irq && cfg_r.reset_out_en
	|-> reset_io_o) else $error("pulse missing");
a_rx_legacy: assert property (age_r == 5'h1F &&
	cfg_r.mode != MODE_LEGACY |-> !rx_data_sync)
	else $error("rx sampled outside legacy");
a_link_drive: assert property (age_r == 5'h1F &&
	cfg_r.mode != MODE_LEGACY |-> !slot_link_oe)
	else $error("slot link driven");
a_reset_strobe: assert property (up_r == 2'h0 |->
	port_a_tx_data && channel_strobe_two) else $error("pins not strobes");
c_irq: cover property (awake_irq);
c_pulse: cover property ($rose(reset_io_o));
c_drive: cover property (slot_link_oe);
endmodule
bind serial_port_pin_functions serial_port_pin_functions_checker chk
	(.clock, .rst, .cfg_in, .cfg_write, .nonmux_bus_sel, .addr_lines,
	.slot_link_in, .slot_link_oe, .port_a_tx_data, .channel_strobe_two,
	.reg_addr, .rx_data_sync, .awake_irq, .reset_io_o);

// file: frame_partner.sv
// Model of the transceiver on the serial frame bus
`timescale 1ns/1ps
module frame_partner
(
	// Bench control: release the lines, pulled high
	input wire logic quiet,
	// Bench control: pull the released slot line low (awake)
	input wire logic awake_pull,
	// Drive from the device on the slot link pin
	input wire logic slot_link_o,
	input wire logic slot_link_oe,
	// Lines to the device
	output logic bit_clock_in,
	output logic frame_sync,
	output logic tx_bit,
	output logic port_a_rx_data,
	output logic slot_link_in
);
// ==========
// Free-running data clock, two clocks per bit, 512 per frame
logic [8:0] pos_r = '0;
logic drv;
initial
begin
	bit_clock_in = 1'b0;
	#1.7;
	// One free clock serves both rates
	forever #3 bit_clock_in = ~bit_clock_in;
end
always @(posedge bit_clock_in)
	pos_r <= pos_r + 9'h001;
assign frame_sync = (pos_r == 9'h000);
assign tx_bit = pos_r[1] ^ pos_r[4];
// Released lines sit at the pull-up level
assign port_a_rx_data = quiet | pos_r[2];
assign drv = quiet | (pos_r[3] ^ pos_r[1]);
// Wire level of the shared pin
// An awake pull overrides the idle level, never the device's drive
assign slot_link_in = slot_link_oe ? slot_link_o : (drv & ~awake_pull);
endmodule

// file: tb_serial_port_pin_functions.sv
// Testbench for the serial pin function mux
`timescale 1ns/1ps
module tb_serial_port_pin_functions;
import serial_pins_pkg::*;
// ==========
// Signals
logic clock, rst, cfg_write, nonmux_bus_sel, quiet;
logic awake_pull, rioe;
port_cfg_t cfg_in;
logic [5:0] addr_lines, reg_addr;
logic bck, fs, txb, rxd, sli, slo, sloe, tx_o, st2, rxs, irq, rio;
int err_count = 0;
int cmp_count = 0;
frame_partner peer (.quiet(quiet), .awake_pull(awake_pull),
	.slot_link_o(slo), .slot_link_oe(sloe), .bit_clock_in(bck),
	.frame_sync(fs),
	.tx_bit(txb), .port_a_rx_data(rxd), .slot_link_in(sli));
serial_port_pin_functions DUT (.clock(clock), .rst(rst),
	.cfg_in(cfg_in), .cfg_write(cfg_write),
	.nonmux_bus_sel(nonmux_bus_sel), .addr_lines(addr_lines),
	.bit_clock_in(bck), .frame_sync(fs), .tx_bit(txb),
	.port_a_rx_data(rxd), .slot_link_in(sli), .slot_link_o(slo),
	.slot_link_oe(sloe), .port_a_tx_data(tx_o),
	.channel_strobe_two(st2), .reg_addr(reg_addr),
	.rx_data_sync(rxs), .awake_irq(irq), .reset_io_o(rio),
	.reset_io_oe(rioe));
// ==========
// Shared tasks
task automatic check(input string nm, input logic [5:0] seen,
	input logic [5:0] exp);
	cmp_count++;
	if (seen !== exp)
	begin
		err_count++;
		$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
	end
endtask
task automatic conclude();
	$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
	if (err_count == 0 && cmp_count > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
// Frames settle after the mode changes take effect
task automatic set_cfg(input if_mode_t m, input logic tf, input logic ro);
	@(posedge clock);
	cfg_in.mode <= m;
	cfg_in.terminal_funcs_en <= tf;
	cfg_in.reset_out_en <= ro;
	cfg_write <= 1'b1;
	@(posedge clock);
	cfg_write <= 1'b0;
	repeat (40) @(posedge clock);
endtask
// Counts high cycles over more than one frame
// Counts are four-state so an unknown output spoils the verdict
task automatic watch(output logic [6:0] no, output logic [6:0] nr,
	output logic [6:0] nt, output logic [6:0] n2);
	no = 0; nr = 0; nt = 0; n2 = 0;
	repeat (80)
	begin
		@(posedge clock);
		#1;
		no += sloe; nr += rxs; nt += tx_o; n2 += st2;
	end
endtask
// ==========
// Scenarios
task automatic t_reset();
	logic [6:0] no, nr, nt, n2;
	watch(no, nr, nt, n2);
	check("strobe_one_moves", 6'(nt > 0 && nt < 80), 6'h01);
	check("strobe_two_moves", 6'(n2 > 0 && n2 < 80), 6'h01);
	$display("t_reset done");
endtask
task automatic t_addr();
	nonmux_bus_sel <= 1'b1;
	for (int i = 0; i < 7; i++)
	begin
		@(posedge clock);
		addr_lines <= (i == 6) ? 6'h3F : 6'(1 << i);
		// Two synchroniser stages plus the output register
		repeat (3) @(posedge clock);
		#1;
		check("reg_addr", reg_addr, (i == 6) ? 6'h3F : 6'(1 << i));
	end
	// Multiplexed bus: dedicated lines are not used
	@(posedge clock);
	nonmux_bus_sel <= 1'b0;
	@(posedge clock);
	#1;
	check("reg_addr_mux", reg_addr, 6'h00);
	$display("t_addr done");
endtask
task automatic t_mode(input if_mode_t m);
	logic [6:0] no, nr, nt, n2;
	quiet <= 1'b0;
	set_cfg(m, 1'b0, 1'b0);
	watch(no, nr, nt, n2);
	check("link_oe", 6'(no > 0 && no < 80), 6'(m == MODE_LEGACY));
	check("rx_sync", 6'(nr > 0), 6'(m == MODE_LEGACY));
	if (m != MODE_HDLC)
		check("pin_one", 6'(nt > 0 && nt < 80), 6'h01);
	else
		check("pin_one_idle", 6'(nt != 0), 6'h00);
	check("pin_two", 6'(n2 > 0 && n2 < 80), 6'h01);
	quiet <= 1'b1;
	$display("t_mode done");
endtask
// Line released high, then pulled low once
task automatic t_awake(input logic tf, input logic ro);
	logic [5:0] ni, nr, ne;
	ni = 0;
	nr = 0;
	ne = 0;
	set_cfg(MODE_HDLC, tf, ro);
	@(posedge clock);
	awake_pull <= 1'b1;
	repeat (24)
	begin
		@(posedge clock);
		#1;
		ni += irq;
		nr += rio;
		ne += rioe;
	end
	@(posedge clock);
	awake_pull <= 1'b0;
	check("irq_count", ni, 6'(tf));
	check("pulse_len", nr, (tf && ro) ? 6'h10 : 6'h00);
	check("pulse_oe", ne, (tf && ro) ? 6'h10 : 6'h00);
	$display("t_awake done");
endtask
// ==========
// Clock, watchdog and main sequence
initial
begin
	clock = 1'b0;
	forever #25 clock = ~clock;
end
initial
begin
	#200000;
	err_count++;
	conclude();
end
initial
begin
	rst = 1'b1;
	cfg_write = 1'b0;
	nonmux_bus_sel = 1'b0;
	quiet = 1'b1;
	awake_pull = 1'b0;
	addr_lines = '0;
	cfg_in = '0;
	cfg_in.strobe_one_slot_b = 5'h03;
	cfg_in.strobe_one_dual = 1'b1;
	cfg_in.strobe_two_slot = 5'h02;
	// Four clocks is the least reset the device accepts
	repeat (4) @(posedge clock);
	rst <= 1'b0;
	t_reset();
	t_addr();
	t_mode(MODE_LEGACY);
	t_mode(MODE_EXTENDED);
	t_mode(MODE_HDLC);
	t_awake(1'b1, 1'b1);
	t_awake(1'b1, 1'b0);
	t_awake(1'b0, 1'b1);
	conclude();
end
endmodule
